// *** lpddr4_channel_pins.sv ***
// pin-side logic of one memory channel: command capture, data lanes, strobes,
// mask/inversion lines and command-bus termination control
// assumes every link pin is asynchronous to mclk and slow enough to oversample
`timescale 1ns/100ps

// How it works
// - six-bit command/address word captured per channel, decoded into commands
// - sixteen-bit data bus, driven by us on reads, received on writes
// - on reads we toggle the strobe in the same cycle data changes
// - one strobe pair per byte lane, complement kept on the second leg
// - one mask/inversion line per byte lane
// - mask/inversion line high for an inverted byte, low for a plain one
// - inversion can be switched off by a mode bit
// - a mode bit chooses inversion or write masking on that line
// - command termination on when the pin and the mode bit are both high
// - the single reset clears all channel state
// - idle state always means every bank is precharged
// - commands sampled only on rising edges of the link clock, write data on either strobe edge
// - enable and select form the command; enable low in idle or active enters power down
module lpddr4_channel_pins (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // command link from the controller
    input  wire logic        ck,
    input  wire logic        cke,
    input  wire logic        cs,
    input  wire logic [5:0]  ca,
    input  wire logic        odt_ca,
    // data lanes
    input  wire logic [15:0] dq_in,
    output logic      [15:0] dq_out,
    output logic             dq_oe,
    input  wire logic [1:0]  dqs_t_in,
    output logic      [1:0]  dqs_t_out,
    output logic      [1:0]  dqs_c_out,
    output logic             dqs_oe,
    input  wire logic [1:0]  dmi_in,
    output logic      [1:0]  dmi_out,
    output logic             dmi_oe,
    // termination
    output logic             ca_term_on,
    // write data toward the core
    output logic      [15:0] wr_data,
    output logic      [1:0]  wr_mask,
    output logic             wr_valid,
    input  wire logic        wr_ready,
    // read data from the core
    input  wire logic [15:0] rd_data,
    output logic             rd_take,
    // status
    output logic             bank_open,
    output logic             power_down
);
    localparam int LN = lpddr4_pin_pkg::LANES;
    localparam int BW = lpddr4_pin_pkg::BYTE_W;
    localparam int SW = 4 + lpddr4_pin_pkg::CA_W + lpddr4_pin_pkg::DQ_W + 2 * LN;

    // two-flop synchronisers on every link pin
    wire  [SW-1:0] pin_raw = {ck, cke, cs, ca, odt_ca, dq_in, dqs_t_in, dmi_in};
    logic [SW-1:0] pin_meta;
    logic [SW-1:0] pin_sync;
    logic          ck_prev;
    logic [LN-1:0] dqs_prev;

    wire        ck_s;
    wire        cke_s;
    wire        cs_s;
    wire [5:0]  ca_s;
    wire        odt_s;
    wire [15:0] dq_s;
    wire [1:0]  dqs_s;
    wire [1:0]  dmi_s;
    assign {ck_s, cke_s, cs_s, ca_s, odt_s, dq_s, dqs_s, dmi_s} = pin_sync;

    lpddr4_pin_pkg::state_t state;
    lpddr4_pin_pkg::state_t next_state;
    logic [5:0] mode;
    logic [2:0] beat;
    logic [2:0] timer;

    // decode
    wire ck_rise     = ck_s & ~ck_prev;
    wire is_cmd      = ck_rise & cs_s & cke_s;
    wire go_sleep    = ck_rise & ~cke_s;
    wire dqs_edge    = dqs_s[0] ^ dqs_prev[0];
    wire dbi_active  = mode[lpddr4_pin_pkg::MR_DBI_BIT]
                     & mode[lpddr4_pin_pkg::MR_DMI_INV_BIT];
    wire mask_active = ~mode[lpddr4_pin_pkg::MR_DMI_INV_BIT];
    wire fifo_ready;
    wire fifo_empty;
    wire write_push  = (state == lpddr4_pin_pkg::ST_WRITE) & dqs_edge & fifo_ready;
    wire write_done  = (state == lpddr4_pin_pkg::ST_WRITE) & (beat == lpddr4_pin_pkg::BURST_BEATS);
    wire read_tick   = (state == lpddr4_pin_pkg::ST_READ) & (timer == lpddr4_pin_pkg::READ_TICK);
    wire read_done   = read_tick & (beat == lpddr4_pin_pkg::BURST_BEATS);
    wire read_beat   = read_tick & ~read_done;
    wire read_entry  = (state != lpddr4_pin_pkg::ST_READ) & (next_state == lpddr4_pin_pkg::ST_READ);
    wire burst_entry = state != next_state;

    // per-lane inversion and masking
    wire [15:0]   rd_enc;
    wire [LN-1:0] rd_flag;
    wire [15:0]   wr_word;
    wire [LN-1:0] wr_lane_mask;
    genvar l;
    generate
        for (l = 0; l < LN; l++) begin : g_lane
            wire [BW-1:0] rd_byte = rd_data[l*BW +: BW];
            wire          w_inv   = dbi_active & dmi_s[l];
            assign rd_flag[l] = dbi_active
                              & ($countones(rd_byte) > lpddr4_pin_pkg::DBI_LIMIT);
            assign rd_enc[l*BW +: BW]  = rd_byte ^ {BW{rd_flag[l]}};
            assign wr_word[l*BW +: BW] = dq_s[l*BW +: BW] ^ {BW{w_inv}};
            assign wr_lane_mask[l]     = mask_active & dmi_s[l];
        end
    endgenerate

    // command sequencing
    always_comb begin
        next_state = state;
        case (state)
            lpddr4_pin_pkg::ST_IDLE: begin
                if (go_sleep) begin
                    next_state = lpddr4_pin_pkg::ST_PWRDN;
                end else if (is_cmd && ca_s == lpddr4_pin_pkg::CMD_ACT) begin
                    next_state = lpddr4_pin_pkg::ST_ACTIVE;
                end else if (is_cmd && ca_s == lpddr4_pin_pkg::CMD_MRW) begin
                    next_state = lpddr4_pin_pkg::ST_MRW;
                end
            end
            lpddr4_pin_pkg::ST_ACTIVE: begin
                if (go_sleep) begin
                    next_state = lpddr4_pin_pkg::ST_PWRDN;
                end else if (is_cmd && ca_s == lpddr4_pin_pkg::CMD_PRE) begin
                    next_state = lpddr4_pin_pkg::ST_IDLE;
                end else if (is_cmd && ca_s == lpddr4_pin_pkg::CMD_RD) begin
                    next_state = lpddr4_pin_pkg::ST_READ;
                end else if (is_cmd && ca_s == lpddr4_pin_pkg::CMD_WR && fifo_empty) begin
                    // a write is dropped unless the previous burst has drained
                    next_state = lpddr4_pin_pkg::ST_WRITE;
                end
            end
            lpddr4_pin_pkg::ST_MRW: begin
                if (ck_rise && cs_s) begin
                    next_state = lpddr4_pin_pkg::ST_IDLE;
                end
            end
            lpddr4_pin_pkg::ST_WRITE: begin
                if (write_done) begin
                    next_state = lpddr4_pin_pkg::ST_ACTIVE;
                end
            end
            lpddr4_pin_pkg::ST_READ: begin
                if (read_done) begin
                    next_state = lpddr4_pin_pkg::ST_ACTIVE;
                end
            end
            lpddr4_pin_pkg::ST_PWRDN: begin
                if (ck_rise && cke_s) begin
                    next_state = bank_open ? lpddr4_pin_pkg::ST_ACTIVE
                                           : lpddr4_pin_pkg::ST_IDLE;
                end
            end
            default: next_state = lpddr4_pin_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pin_meta   <= '0;
            pin_sync   <= '0;
            ck_prev    <= 1'b0;
            dqs_prev   <= '0;
            state      <= lpddr4_pin_pkg::ST_IDLE;
            mode       <= lpddr4_pin_pkg::MR_RESET;
            bank_open  <= 1'b0;
            power_down <= 1'b0;
            ca_term_on <= 1'b0;
        end else begin
            pin_meta   <= pin_raw;
            pin_sync   <= pin_meta;
            ck_prev    <= ck_s;
            dqs_prev   <= dqs_s;
            state      <= next_state;
            mode       <= (state == lpddr4_pin_pkg::ST_MRW && ck_rise && cs_s) ? ca_s : mode;
            bank_open  <= next_state != lpddr4_pin_pkg::ST_IDLE
                        && (bank_open || next_state == lpddr4_pin_pkg::ST_ACTIVE);
            power_down <= next_state == lpddr4_pin_pkg::ST_PWRDN;
            ca_term_on <= odt_s & mode[lpddr4_pin_pkg::MR_ODT_BIT];
        end
    end

    // burst beat counter and read pacing
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            beat  <= '0;
            timer <= lpddr4_pin_pkg::TIMER_ZERO;
        end else begin
            beat  <= burst_entry ? '0 : beat + 3'((write_push | read_beat) ? 1 : 0);
            timer <= (read_entry || read_tick) ? lpddr4_pin_pkg::TIMER_ZERO : timer + 3'h1;
        end
    end

    // read drivers: data and strobe change on the same edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dq_out    <= '0;
            dmi_out   <= '0;
            dqs_t_out <= '0;
            dqs_c_out <= '1;
            dq_oe     <= 1'b0;
            dqs_oe    <= 1'b0;
            dmi_oe    <= 1'b0;
            rd_take   <= 1'b0;
        end else begin
            dq_oe   <= next_state == lpddr4_pin_pkg::ST_READ;
            dqs_oe  <= next_state == lpddr4_pin_pkg::ST_READ;
            dmi_oe  <= next_state == lpddr4_pin_pkg::ST_READ;
            rd_take <= read_beat;
            if (read_entry) begin
                // preamble: strobe parked low, stale flags cleared
                dq_out    <= '0;
                dmi_out   <= '0;
                dqs_t_out <= '0;
                dqs_c_out <= '1;
            end else if (read_beat) begin
                dq_out    <= rd_enc;
                dmi_out   <= rd_flag;
                dqs_t_out <= ~dqs_t_out;
                dqs_c_out <= dqs_t_out;
            end
        end
    end

    stream_fifo #(
        .W     (lpddr4_pin_pkg::FIFO_W),
        .DEPTH (lpddr4_pin_pkg::FIFO_DEPTH)
    ) u_wr_fifo (
        .clk       (mclk),
        .rst       (rst),
        .in_data   ({wr_lane_mask, wr_word}),
        .in_valid  (write_push),
        .in_ready  (fifo_ready),
        .out_data  ({wr_mask, wr_data}),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .empty     (fifo_empty)
    );

    // checks
    sequence s_read_start;
        $rose(state == lpddr4_pin_pkg::ST_READ);
    endsequence
    sequence s_first_beat;
        !rd_take [*5] ##1 rd_take;
    endsequence

    property p_read_pacing;
        @(posedge mclk) disable iff (rst) s_read_start |-> s_first_beat;
    endproperty
    a_read_pacing: assert property (p_read_pacing) else $error("first read beat mistimed");

    property p_strobe_with_data;
        @(posedge mclk) disable iff (rst) rd_take |-> $changed(dqs_t_out) && dq_oe && dqs_oe;
    endproperty
    a_strobe_with_data: assert property (p_strobe_with_data) else $error("strobe not with data");

    property p_strobe_pair;
        @(posedge mclk) disable iff (rst) dqs_oe |-> dqs_c_out == ~dqs_t_out;
    endproperty
    a_strobe_pair: assert property (p_strobe_pair) else $error("strobe legs not complementary");

    property p_inv_off;
        @(posedge mclk) disable iff (rst) !dbi_active && dmi_oe |-> dmi_out == '0;
    endproperty
    a_inv_off: assert property (p_inv_off) else $error("inversion flag while disabled");

    property p_inv_flag;
        @(posedge mclk) disable iff (rst)
            read_beat && dbi_active
            && $countones(rd_data[BW-1:0]) > lpddr4_pin_pkg::DBI_LIMIT |=> dmi_out[0];
    endproperty
    a_inv_flag: assert property (p_inv_flag) else $error("inverted byte not flagged");

    property p_mask_mode;
        @(posedge mclk) disable iff (rst)
            write_push && dmi_s[0] |-> wr_lane_mask[0] == mask_active
            && wr_word[BW-1:0] == (dbi_active ? ~dq_s[BW-1:0] : dq_s[BW-1:0]);
    endproperty
    a_mask_mode: assert property (p_mask_mode) else $error("write lane decode wrong");

    property p_idle_precharged;
        @(posedge mclk) disable iff (rst) state == lpddr4_pin_pkg::ST_IDLE |-> !bank_open;
    endproperty
    a_idle_precharged: assert property (p_idle_precharged) else $error("bank open in idle");

    property p_activate;
        @(posedge mclk) disable iff (rst)
            is_cmd && ca_s == lpddr4_pin_pkg::CMD_ACT && state == lpddr4_pin_pkg::ST_IDLE
            |=> state == lpddr4_pin_pkg::ST_ACTIVE ##1 bank_open;
    endproperty
    a_activate: assert property (p_activate) else $error("activate not taken");

    property p_sleep;
        @(posedge mclk) disable iff (rst)
            go_sleep && (state == lpddr4_pin_pkg::ST_IDLE || state == lpddr4_pin_pkg::ST_ACTIVE)
            |=> power_down;
    endproperty
    a_sleep: assert property (p_sleep) else $error("power down not entered");

    property p_term;
        @(posedge mclk) disable iff (rst)
            odt_s && mode[lpddr4_pin_pkg::MR_ODT_BIT] |=> ca_term_on;
    endproperty
    a_term: assert property (p_term) else $error("termination not enabled");

endmodule // lpddr4_channel_pins

// *** lpddr4_pin_pkg.sv ***
// constants, command codes and states for one channel's pin-side logic
// assumes a 250 MHz core clock that oversamples the controller's link clock
package lpddr4_pin_pkg;

    localparam int CA_W   = 6;
    localparam int DQ_W   = 16;
    localparam int BYTE_W = 8;
    localparam int LANES  = DQ_W / BYTE_W;
    localparam int FIFO_W = DQ_W + LANES;
    localparam int FIFO_DEPTH = 4;

    // command words, first word of a command with select high
    localparam logic [CA_W-1:0] CMD_ACT = 6'h01;
    localparam logic [CA_W-1:0] CMD_RD  = 6'h02;
    localparam logic [CA_W-1:0] CMD_WR  = 6'h04;
    localparam logic [CA_W-1:0] CMD_MRW = 6'h06;
    localparam logic [CA_W-1:0] CMD_PRE = 6'h10;

    // mode word fields and reset value
    localparam int MR_DBI_BIT     = 0;
    localparam int MR_DMI_INV_BIT = 1;
    localparam int MR_ODT_BIT     = 2;
    localparam logic [CA_W-1:0] MR_RESET = 6'h00;

    // read inversion threshold: more ones than this in a byte inverts it
    localparam int DBI_LIMIT = 4;

    // burst length in data beats
    localparam logic [2:0] BURST_BEATS = 3'h4;

    // read beat spacing: least time, rounded up to core cycles
    localparam int CLK_PERIOD_NS = 4;
    localparam int READ_HALF_NS  = 20;
    localparam int READ_HALF_CYC = (READ_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] READ_TICK = 3'(READ_HALF_CYC - 1);
    localparam logic [2:0] TIMER_ZERO = 3'h0;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_ACTIVE = 3'b001,
        ST_MRW    = 3'b010,
        ST_WRITE  = 3'b011,
        ST_READ   = 3'b100,
        ST_PWRDN  = 3'b101
    } state_t;

endpackage

// *** stream_fifo.sv ***
// small flop-based fifo with valid/ready on both sides
// assumes DEPTH is a power of two so the pointers wrap by themselves
`timescale 1ns/100ps

module stream_fifo #(
    parameter int W     = 18,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // filling side
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    // draining side
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    // status
    output logic              empty
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   count;

    wire         push = in_valid & in_ready;
    wire         pop  = out_valid & out_ready;
    wire [AW:0]  next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    assign out_data = mem[rp];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end

    // flags registered from the next count so they are honest at the edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp        <= '0;
            rp        <= '0;
            count     <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
            empty     <= 1'b1;
        end else begin
            wp        <= push ? wp + AW'(1) : wp;
            rp        <= pop ? rp + AW'(1) : rp;
            count     <= next_count;
            in_ready  <= next_count != (AW+1)'(DEPTH);
            out_valid <= next_count != '0;
            empty     <= next_count == '0;
        end
    end

endmodule // stream_fifo

// *** lpddr4_ctrl_model.sv ***
// controller-side model of one channel: command frames, write bursts, bus release
// assumes the bench calls one task at a time, aligned 1 ns after a mclk rise
`timescale 1ns/100ps

module lpddr4_ctrl_model (
    // pacing clock
    input  wire logic        mclk,
    // command link
    output logic             ck,
    output logic             cke,
    output logic             cs,
    output logic [5:0]       ca,
    output logic             odt_ca,
    // resolved shared lines
    output logic [15:0]      dq_in,
    output logic [1:0]       dqs_t_in,
    output logic [1:0]       dmi_in,
    // device drive
    input  wire logic [15:0] dq_out,
    input  wire logic        dq_oe,
    input  wire logic [1:0]  dqs_t_out,
    input  wire logic        dqs_oe,
    input  wire logic [1:0]  dmi_out,
    input  wire logic        dmi_oe
);
    logic        m_oe = 1'b0;
    logic        s_oe = 1'b0;
    logic [15:0] m_dq = 16'h0000;
    logic [15:0] last_dq = 16'h0000;
    logic [1:0]  m_dqs = 2'h0;
    logic [1:0]  m_dmi = 2'h0;
    logic [1:0]  last_dqs = 2'h0;
    logic [1:0]  last_dmi = 2'h0;

    // released lines float: show the inverse of the last level, not a stale copy
    assign dq_in    = m_oe ? m_dq : (dq_oe ? dq_out : ~last_dq);
    assign dmi_in   = m_oe ? m_dmi : (dmi_oe ? dmi_out : ~last_dmi);
    assign dqs_t_in = s_oe ? m_dqs : (dqs_oe ? dqs_t_out : ~last_dqs);

    always @(posedge mclk) begin
        if (m_oe || dq_oe) last_dq <= dq_in;
        if (m_oe || dmi_oe) last_dmi <= dmi_in;
        if (s_oe || dqs_oe) last_dqs <= dqs_t_in;
    end

    initial begin
        ck = 1'b0;
        cke = 1'b1;
        cs = 1'b0;
        ca = 6'h00;
        odt_ca = 1'b0;
    end

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic term(input logic v);
        odt_ca = v;
    endtask

    // one frame: word held across a single link clock rise, clock still otherwise
    task automatic cmd(input logic [5:0] word, input logic en);
        cs = 1'b1;
        cke = en;
        ca = word;
        step(10);
        ck = 1'b1;
        step(10);
        ck = 1'b0;
        cs = 1'b0;
        cke = 1'b1;
        step(10);
    endtask

    task automatic mrw(input logic [5:0] mode);
        cmd(lpddr4_pin_pkg::CMD_MRW, 1'b1);
        cmd(mode, 1'b1);
    endtask

    task automatic write(input logic [63:0] d, input logic [7:0] m);
        s_oe = 1'b1;
        m_dqs = 2'b00;
        cmd(lpddr4_pin_pkg::CMD_WR, 1'b1);
        for (int i = 0; i < 4; i++) begin
            m_oe = 1'b1;
            m_dq = d[16*i +: 16];
            m_dmi = m[2*i +: 2];
            step(5);
            m_dqs = ~m_dqs;
            step(5);
        end
        m_oe = 1'b0;
        s_oe = 1'b0;
    endtask
endmodule // lpddr4_ctrl_model

// *** lpddr4_channel_pin_interface_tb_top.sv ***
// self-checking bench for one channel's pin-side logic
// assumes the controller model drives the link and the bench plays the core
`timescale 1ns/100ps

`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end

module lpddr4_channel_pin_interface_tb_top;
    logic        mclk, rst, wr_ready;
    logic        ck, cke, cs, odt_ca, dq_oe, dqs_oe, dmi_oe, ca_term_on;
    logic        wr_valid, rd_take, bank_open, power_down;
    logic [5:0]  ca;
    logic [15:0] dq_in, dq_out, wr_data, rd_data;
    logic [1:0]  dqs_t_in, dqs_t_out, dqs_c_out, dmi_in, dmi_out, wr_mask;
    logic [15:0] rd_words [4] = '{16'hff01, 16'h1f0f, 16'h0000, 16'hf8e0};
    int          n_errors = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          ridx = 0;

    assign rd_data = rd_words[ridx[1:0]];

    lpddr4_channel_pins u_dut (.mclk(mclk), .rst(rst), .ck(ck), .cke(cke), .cs(cs), .ca(ca),
        .odt_ca(odt_ca), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_t_in(dqs_t_in),
        .dqs_t_out(dqs_t_out), .dqs_c_out(dqs_c_out), .dqs_oe(dqs_oe), .dmi_in(dmi_in),
        .dmi_out(dmi_out), .dmi_oe(dmi_oe), .ca_term_on(ca_term_on), .wr_data(wr_data),
        .wr_mask(wr_mask), .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
        .rd_take(rd_take), .bank_open(bank_open), .power_down(power_down));

    lpddr4_ctrl_model u_ctrl (.mclk(mclk), .ck(ck), .cke(cke), .cs(cs), .ca(ca),
        .odt_ca(odt_ca), .dq_in(dq_in), .dqs_t_in(dqs_t_in), .dmi_in(dmi_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .dqs_t_out(dqs_t_out), .dqs_oe(dqs_oe),
        .dmi_out(dmi_out), .dmi_oe(dmi_oe));

    always #2 mclk = ~mclk;

    // ceiling well above the roughly 900 cycles the sequence needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 8000) begin
            n_errors++;
            test_done();
        end
    end

    // next read word handed over once the current one is taken
    always @(posedge mclk) begin
        if (rd_take === 1'b1) begin
            #1;
            ridx = ridx + 1;
        end
    end

    function automatic logic flag(input logic [7:0] b, input logic inv);
        return inv && ($countones(b) > lpddr4_pin_pkg::DBI_LIMIT);
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic t_idle();
        `CHK("bank_open", 1'b0, bank_open)
        `CHK("dq_oe", 1'b0, dq_oe)
        `CHK("dqs_c_out", 2'b11, dqs_c_out)
        `CHK("wr_valid", 1'b0, wr_valid)
        `CHK("ca_term_on", 1'b0, ca_term_on)
    endtask

    task automatic t_mode(input logic pin, input logic [5:0] mode);
        u_ctrl.term(pin);
        u_ctrl.mrw(mode);
        cyc(4);
        `CHK("ca_term_on", pin & mode[lpddr4_pin_pkg::MR_ODT_BIT], ca_term_on)
    endtask

    task automatic t_cmd(input logic [5:0] w, input logic en, input logic op, input logic pd);
        u_ctrl.cmd(w, en);
        `CHK("bank_open", op, bank_open)
        `CHK("power_down", pd, power_down)
        `CHK("dq_oe", 1'b0, dq_oe)
    endtask

    // far side stalls through the burst, so the buffer fills and a second write is refused
    task automatic t_write(input logic inv, input logic extra);
        logic [63:0] d;
        logic [7:0]  m;
        logic [15:0] ed;
        int          k;
        d = 64'ha55a_0ff0_ffff_1234;
        m = 8'b10_01_11_00;
        wr_ready = 1'b0;
        u_ctrl.write(d, m);
        if (extra) u_ctrl.write(~d, ~m);
        for (int i = 0; i < 4; i++) begin
            k = 0;
            while (wr_valid !== 1'b1 && k < 20) begin
                cyc(1);
                k++;
            end
            ed = d[16*i +: 16];
            if (inv) ed = ed ^ {{8{m[2*i+1]}}, {8{m[2*i]}}};
            `CHK("wr_data", ed, wr_data)
            `CHK("wr_mask", inv ? 2'b00 : m[2*i +: 2], wr_mask)
            wr_ready = 1'b1;
            cyc(1);
            wr_ready = 1'b0;
        end
        cyc(2);
        `CHK("wr_valid", 1'b0, wr_valid)
    endtask

    task automatic t_read(input logic inv);
        logic [15:0] w;
        logic [15:0] ev;
        logic        t;
        int          k;
        ridx = 0;
        fork
            u_ctrl.cmd(lpddr4_pin_pkg::CMD_RD, 1'b1);
            begin
                k = 0;
                while (dq_oe !== 1'b1 && k < 30) begin
                    cyc(1);
                    k++;
                end
                `CHK("dqs_oe", 1'b1, dqs_oe)
                for (int c = 1; c <= 25; c++) begin
                    cyc(1);
                    w = rd_words[(c/5-1) & 3];
                    t = ((c / 5) % 2 == 1);
                    ev = w ^ {{8{flag(w[15:8], inv)}}, {8{flag(w[7:0], inv)}}};
                    if (c % 5 == 0 && c < 25) begin
                        `CHK("rd_take", 1'b1, rd_take)
                        `CHK("dmi_out", {flag(w[15:8], inv), flag(w[7:0], inv)}, dmi_out)
                        `CHK("dq_out", ev, dq_out)
                        `CHK("dqs_t_out", {2{t}}, dqs_t_out)
                        `CHK("dqs_c_out", {2{~t}}, dqs_c_out)
                    end else begin
                        `CHK("rd_take", 1'b0, rd_take)
                    end
                end
                `CHK("dq_oe", 1'b0, dq_oe)
                `CHK("dmi_oe", 1'b0, dmi_oe)
            end
        join
    endtask

    task automatic t_reset_mid();
        t_mode(1'b1, 6'h04);
        t_cmd(lpddr4_pin_pkg::CMD_ACT, 1'b1, 1'b1, 1'b0);
        rst = 1'b1;
        cyc(2);
        t_idle();
        rst = 1'b0;
        cyc(4);
        t_idle();
    endtask

    task automatic test_done();
        if (n_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        wr_ready = 1'b0;
        cyc(16);
        rst = 1'b0;
        cyc(4);
        t_idle();
        t_mode(1'b0, 6'h04);
        t_mode(1'b1, 6'h04);
        t_mode(1'b1, 6'h03);
        t_cmd(lpddr4_pin_pkg::CMD_ACT, 1'b1, 1'b1, 1'b0);
        t_write(1'b1, 1'b1);
        t_read(1'b1);
        t_cmd(lpddr4_pin_pkg::CMD_PRE, 1'b1, 1'b0, 1'b0);
        t_mode(1'b1, 6'h00);
        t_cmd(lpddr4_pin_pkg::CMD_ACT, 1'b1, 1'b1, 1'b0);
        t_write(1'b0, 1'b0);
        t_read(1'b0);
        t_cmd(lpddr4_pin_pkg::CMD_PRE, 1'b1, 1'b0, 1'b0);
        t_cmd(lpddr4_pin_pkg::CMD_RD, 1'b1, 1'b0, 1'b0);
        t_cmd(6'h00, 1'b0, 1'b0, 1'b1);
        t_cmd(6'h00, 1'b1, 1'b0, 1'b0);
        t_reset_mid();
        test_done();
    end
endmodule // lpddr4_channel_pin_interface_tb_top
